// [include/rtcd_pkg.sv]
package rtcd_pkg;

   // ****************************************************************
   // command byte layout
   // ****************************************************************
   localparam int CMD_EXT_BIT  = 7;
   localparam int CMD_FC_MSB   = 6;
   localparam int CMD_FC_LSB   = 4;
   localparam int CMD_RSV_BIT  = 3;
   localparam int SEL_BANK_BIT = 2;

   // ****************************************************************
   // function codes
   // ****************************************************************
   localparam logic [2:0] FC_SET_POINTER = 3'h0;
   localparam logic [2:0] FC_READ_FLAGS  = 3'h1;
   localparam logic [2:0] FC_RESET_PRESC = 3'h2;
   localparam logic [2:0] FC_TIME_ADJUST = 3'h3;
   localparam logic [2:0] FC_CLR_DATE_IG = 3'h4;
   localparam logic [2:0] FC_SET_DATE_IG = 3'h5;
   localparam logic [2:0] FC_CLR_ALARM   = 3'h6;
   localparam logic [2:0] FC_INVALID     = 3'h7;

   // ****************************************************************
   // register select and data layout
   // ****************************************************************
   localparam logic [1:0] FIELD_HOURS   = 2'h0;
   localparam logic [1:0] FIELD_MINUTES = 2'h1;
   localparam logic [1:0] FIELD_DAYS    = 2'h2;
   localparam logic [1:0] FIELD_MONTHS  = 2'h3;
   localparam logic [7:0] MASK_HOURS    = 8'h3F;
   localparam logic [7:0] MASK_MINUTES  = 8'h7F;
   localparam logic [7:0] MASK_DAYS     = 8'h3F;
   localparam logic [7:0] MASK_MONTHS   = 8'h1F;
   localparam int         NUM_REGS      = 8;

   // ****************************************************************
   // flags byte positions
   // ****************************************************************
   localparam int FLAG_POWER_LOSS  = 0;
   localparam int FLAG_ALARM_MATCH = 1;
   localparam int FLAG_DATE_IGNORE = 2;
   localparam int FLAG_SECONDS     = 3;
   localparam int FLAG_MINUTES     = 4;

   // ****************************************************************
   // timing, thresholds and reset values
   // ****************************************************************
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [7:0] SEC_CARRY_MIN   = 8'h30;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [2:0] FC_RESET        = FC_SET_POINTER;
   localparam logic [2:0] PTR_RESET       = 3'h0;
   localparam logic [4:0] ADDR_FIXED_DEF  = 5'h14;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WRITE,
      ST_READ
   } rtcd_state_t;

endpackage

// [include/rtcd_reg_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface rtcd_reg_if;
   logic       we;
   logic [2:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctrl (output we, output idx, output wdata, input rdata);
   modport bank (input we, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// [core/rtcd_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ****************************************************************
   // two-stage synchroniser per bit
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_q;
         logic stab_q;
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_q <= 1'b1;
               stab_q <= 1'b1;
            end else begin
               meta_q <= async_in[gi];
               stab_q <= meta_q;
            end
         end
         assign sync_out[gi] = stab_q;
      end
   endgenerate

endmodule
`default_nettype wire

// [core/rtcd_regbank.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_regbank
   import rtcd_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // register access
   rtcd_reg_if.bank  regs
);

   logic [7:0] store_q [NUM_REGS];
   logic [7:0] wmask;

   // ****************************************************************
   // field masks
   // ****************************************************************
   // drop unused bits
   assign wmask = (regs.idx[1:0] == FIELD_HOURS)   ? MASK_HOURS   :
                  (regs.idx[1:0] == FIELD_MINUTES) ? MASK_MINUTES :
                  (regs.idx[1:0] == FIELD_DAYS)    ? MASK_DAYS    : MASK_MONTHS;

   assign regs.rdata = store_q[regs.idx];

   // ****************************************************************
   // storage
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               store_q[gi] <= REG_RESET;
            end else if (regs.we && (regs.idx == 3'(gi))) begin
               store_q[gi] <= regs.wdata & wmask;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// [core/rtcd_cmd_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_cmd_decoder
   import rtcd_pkg::*;
#(
   parameter logic [4:0] ADDR_FIXED = ADDR_FIXED_DEF
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // serial bus pins
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // address straps and supply sensing
   input  wire logic [1:0] addr_pins,
   input  wire logic       external_supply_fail_input,
   // counter chain
   input  wire logic [7:0] seconds_bcd,
   input  wire logic       alarm_event,
   input  wire logic       seconds_ind,
   input  wire logic       minutes_ind,
   output logic            prescaler_clear,
   output logic            seconds_clear,
   output logic            minute_carry,
   // flags
   output logic            date_ignore_flag,
   output logic            alarm_match_flag,
   output logic            power_loss_flag
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   wire logic [4:0] raw_in;
   wire logic [4:0] syn_in;
   wire logic       scl_s;
   wire logic       sda_s;
   wire logic [1:0] strap_s;
   wire logic       supply_ok_s;

   assign raw_in = {scl, sda_in, addr_pins, external_supply_fail_input};

   rtcd_sync #(
      .WIDTH (5)
   ) u_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in (raw_in),
      .sync_out (syn_in)
   );

   assign scl_s       = syn_in[4];
   assign sda_s       = syn_in[3];
   assign strap_s     = syn_in[2:1];
   assign supply_ok_s = syn_in[0];

   // ****************************************************************
   // state
   // ****************************************************************
   rtcd_state_t state_q;
   logic        scl_p_q;
   logic        sda_p_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic        ack_slot_q;
   logic        first_byte_q;
   logic        master_ack_q;
   logic [2:0]  fc_q;
   logic [2:0]  ptr_q;
   logic        date_ign_q;
   logic        alarm_q;
   logic        pwr_q;
   logic        presc_q;
   logic        sec_clr_q;
   logic        carry_q;
   logic        oe_n_q;
   logic        sda_out_q;

   rtcd_reg_if u_reg_if ();

   // ****************************************************************
   // bus events
   // ****************************************************************
   wire logic scl_rise;
   wire logic scl_fall;
   wire logic start_det;
   wire logic stop_det;
   wire logic byte_done;
   wire logic ack_end;
   wire logic ack_rise;

   assign scl_rise  = scl_s & ~scl_p_q;
   assign scl_fall  = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign byte_done = scl_fall & ~ack_slot_q & (bit_cnt_q == BITS_PER_BYTE)
                      & (state_q != ST_IDLE);
   assign ack_end   = scl_fall & ack_slot_q;
   assign ack_rise  = scl_rise & ack_slot_q;

   // ****************************************************************
   // command decode
   // ****************************************************************
   wire logic [2:0] cmd_fc;
   wire logic       cmd_ok;
   wire logic       addr_match;
   wire logic       is_cmd_byte;
   wire logic       data_ok;
   wire logic       give_ack;
   wire logic       cmd_take;
   wire logic       read_step;
   wire logic [2:0] ptr_next;
   wire logic [7:0] flags_byte;
   wire logic [7:0] tx_byte;
   wire logic       tx_start;

   assign cmd_fc      = shift_q[CMD_FC_MSB:CMD_FC_LSB];
   assign cmd_ok      = ~shift_q[CMD_EXT_BIT] & (cmd_fc != FC_INVALID)
                        & ~((cmd_fc == FC_SET_POINTER) & shift_q[CMD_RSV_BIT]);
   assign addr_match  = (shift_q[7:1] == {ADDR_FIXED, strap_s});
   assign is_cmd_byte = (state_q == ST_WRITE) & first_byte_q;
   assign data_ok     = (fc_q == FC_SET_POINTER);
   assign give_ack    = ((state_q == ST_ADDR) & addr_match)
                        | ((state_q == ST_WRITE) & (first_byte_q ? cmd_ok : data_ok));
   assign cmd_take    = byte_done & is_cmd_byte & cmd_ok;
   assign ptr_next    = {ptr_q[SEL_BANK_BIT], ptr_q[1:0] + 2'h1};
   assign read_step   = ack_rise & (state_q == ST_READ) & data_ok;
   assign tx_start    = ack_end & (((state_q == ST_ADDR) & shift_q[0])
                                   | ((state_q == ST_READ) & master_ack_q));

   assign flags_byte  = (8'(pwr_q)       << FLAG_POWER_LOSS)
                      | (8'(alarm_q)     << FLAG_ALARM_MATCH)
                      | (8'(date_ign_q)  << FLAG_DATE_IGNORE)
                      | (8'(seconds_ind) << FLAG_SECONDS)
                      | (8'(minutes_ind) << FLAG_MINUTES);
   assign tx_byte     = (fc_q == FC_READ_FLAGS) ? flags_byte : u_reg_if.rdata;

   assign u_reg_if.we    = byte_done & (state_q == ST_WRITE) & ~first_byte_q & data_ok;
   assign u_reg_if.idx   = ptr_q;
   assign u_reg_if.wdata = shift_q;

   rtcd_regbank u_bank (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .regs    (u_reg_if.bank)
   );

   // ****************************************************************
   // edge history
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // ****************************************************************
   // byte framing
   // ****************************************************************
   // a refused byte drops the transfer; only a new start revives it
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= ST_IDLE;
         bit_cnt_q    <= 4'h0;
         ack_slot_q   <= 1'b0;
         first_byte_q <= 1'b0;
      end else if (start_det) begin
         state_q    <= ST_ADDR;
         bit_cnt_q  <= 4'h0;
         ack_slot_q <= 1'b0;
      end else if (stop_det) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         ack_slot_q <= 1'b0;
      end else if (state_q != ST_IDLE) begin
         if (ack_rise) begin
            bit_cnt_q <= 4'h0;
         end else if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         if (byte_done) begin
            ack_slot_q <= 1'b1;
            if (!give_ack && state_q != ST_READ) begin
               state_q <= ST_IDLE;
            end
         end else if (ack_end) begin
            ack_slot_q <= 1'b0;
            if (state_q == ST_ADDR) begin
               state_q      <= shift_q[0] ? ST_READ : ST_WRITE;
               first_byte_q <= 1'b1;
            end else if (state_q == ST_WRITE) begin
               first_byte_q <= 1'b0;
            end else if (!master_ack_q) begin
               state_q <= ST_IDLE;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q      <= 8'h00;
         master_ack_q <= 1'b0;
      end else if (scl_rise && !ack_slot_q && state_q != ST_IDLE) begin
         shift_q <= {shift_q[6:0], sda_s};
      end else if (ack_rise) begin
         master_ack_q <= ~sda_s;
      end
   end

   // ****************************************************************
   // open-drain data driver
   // ****************************************************************
   // data changes only after scl falls, so no false start or stop
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         oe_n_q    <= 1'b1;
         tx_q      <= 8'h00;
         sda_out_q <= 1'b0;
      end else if (start_det || stop_det) begin
         oe_n_q <= 1'b1;
      end else if (byte_done) begin
         oe_n_q <= (state_q == ST_READ) ? 1'b1 : ~give_ack;
      end else if (tx_start) begin
         oe_n_q <= tx_byte[7];
         tx_q   <= {tx_byte[6:0], 1'b0};
      end else if (ack_end) begin
         oe_n_q <= 1'b1;
      end else if (scl_fall && state_q == ST_READ && bit_cnt_q != 4'h0) begin
         oe_n_q <= tx_q[7];
         tx_q   <= {tx_q[6:0], 1'b0};
      end
   end

   // ****************************************************************
   // function code and pointer
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fc_q  <= FC_RESET;
         ptr_q <= PTR_RESET;
      end else if (cmd_take) begin
         fc_q <= cmd_fc;
         if (cmd_fc == FC_SET_POINTER) begin
            ptr_q <= shift_q[2:0];
         end
      end else if (u_reg_if.we || read_step) begin
         ptr_q <= ptr_next;
      end
   end

   // ****************************************************************
   // counter chain strobes
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         presc_q   <= 1'b0;
         sec_clr_q <= 1'b0;
         carry_q   <= 1'b0;
      end else begin
         presc_q   <= cmd_take & (cmd_fc == FC_RESET_PRESC);
         sec_clr_q <= cmd_take & ((cmd_fc == FC_RESET_PRESC) | (cmd_fc == FC_TIME_ADJUST));
         carry_q   <= cmd_take & (cmd_fc == FC_TIME_ADJUST) & (seconds_bcd >= SEC_CARRY_MIN);
      end
   end

   // ****************************************************************
   // flags
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         date_ign_q <= 1'b0;
         alarm_q    <= 1'b0;
         pwr_q      <= 1'b0;
      end else begin
         if (cmd_take && cmd_fc == FC_SET_DATE_IG) begin
            date_ign_q <= 1'b1;
         end else if (cmd_take && cmd_fc == FC_CLR_DATE_IG) begin
            date_ign_q <= 1'b0;
         end
         // set wins over the clear
         if (alarm_event) begin
            alarm_q <= 1'b1;
         end else if (cmd_take && cmd_fc == FC_CLR_ALARM) begin
            alarm_q <= 1'b0;
         end
         pwr_q <= ~supply_ok_s;
      end
   end

   assign sda_out          = sda_out_q;
   assign sda_oe_n         = oe_n_q;
   assign prescaler_clear  = presc_q;
   assign seconds_clear    = sec_clr_q;
   assign minute_carry     = carry_q;
   assign date_ignore_flag = date_ign_q;
   assign alarm_match_flag = alarm_q;
   assign power_loss_flag  = pwr_q;

endmodule
`default_nettype wire

// [tb/rtcd_cmd_decoder_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_sva (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       arst_n,
   // bus pins
   input wire logic       scl,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   // counter chain and flags
   input wire logic       external_supply_fail_input,
   input wire logic [7:0] seconds_bcd,
   input wire logic       alarm_event,
   input wire logic       prescaler_clear,
   input wire logic       seconds_clear,
   input wire logic       minute_carry,
   input wire logic       alarm_match_flag,
   input wire logic       power_loss_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_presc_no_carry;
      prescaler_clear |-> seconds_clear && !minute_carry;
   endproperty
   a_presc_no_carry: assert property (p_presc_no_carry) else $error("prescaler reset carried");
   property p_carry_pair;
      minute_carry |-> seconds_clear && !prescaler_clear;
   endproperty
   a_carry_pair: assert property (p_carry_pair) else $error("carry without seconds clear");
   property p_carry_value;
      seconds_clear && !prescaler_clear |-> minute_carry == ($past(seconds_bcd) >= 8'h30);
   endproperty
   a_carry_value: assert property (p_carry_value) else $error("carry threshold wrong");
   property p_presc_pulse;
      prescaler_clear |=> !prescaler_clear && !seconds_clear;
   endproperty
   a_presc_pulse: assert property (p_presc_pulse) else $error("clear pulse too long");
   property p_pwr_low;
      !external_supply_fail_input [*5] |-> power_loss_flag;
   endproperty
   a_pwr_low: assert property (p_pwr_low) else $error("power loss not shown");
   property p_pwr_high;
      external_supply_fail_input [*5] |-> !power_loss_flag;
   endproperty
   a_pwr_high: assert property (p_pwr_high) else $error("power loss stuck");
   property p_alarm_set;
      alarm_event |=> alarm_match_flag;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm match not set");
   property p_drive_in_low;
      $fell(sda_oe_n) || $rose(sda_oe_n) |-> !scl && !sda_out;
   endproperty
   a_drive_in_low: assert property (p_drive_in_low) else $error("data moved with clock high");
   property p_ack_stands;
      $fell(sda_oe_n) |-> !sda_oe_n [*4];
   endproperty
   a_ack_stands: assert property (p_ack_stands) else $error("low drive too short");
   c_presc: cover property (prescaler_clear);
   c_carry: cover property (minute_carry);
   c_drive: cover property ($fell(sda_oe_n));
endmodule
bind rtcd_cmd_decoder rtcd_sva u_sva (
   .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .external_supply_fail_input(external_supply_fail_input), .seconds_bcd(seconds_bcd),
   .alarm_event(alarm_event), .prescaler_clear(prescaler_clear),
   .seconds_clear(seconds_clear), .minute_carry(minute_carry),
   .alarm_match_flag(alarm_match_flag), .power_loss_flag(power_loss_flag));
`default_nettype wire

// [tb/rtcd_i2c_master.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_i2c_master (
   // clock
   input  wire logic       sys_clk,
   // bus, open drain
   output logic            scl,
   output logic            sda_m,
   input  wire logic       sda_wire,
   // one result per byte
   output logic            res_stb,
   output logic [8:0]      res_val
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
      res_stb = 1'b0;
      res_val = 9'h000;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // data moves 2 cycles after the fall, so no false start or stop
   task automatic bit_io(input logic b, output logic s);
      gap(2);
      sda_m = b;
      gap(6);
      scl = 1'b1;
      gap(8);
      s = sda_wire;
      scl = 1'b0;
   endtask
   task automatic post(input logic [8:0] v);
      res_val = v;
      res_stb = 1'b1;
      gap(1);
      res_stb = 1'b0;
   endtask
   task automatic start;
      gap(2);
      sda_m = 1'b1;
      gap(6);
      scl = 1'b1;
      gap(8);
      sda_m = 1'b0;
      gap(8);
      scl = 1'b0;
   endtask
   // clock stands high after the stop
   task automatic stop;
      gap(2);
      sda_m = 1'b0;
      gap(6);
      scl = 1'b1;
      gap(8);
      sda_m = 1'b1;
      gap(8);
   endtask
   task automatic wbyte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      post({8'h00, ~s});
   endtask
   task automatic rbyte(input logic last);
      logic [7:0] v;
      logic       s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(last, s);
      post({1'b1, v});
   endtask
endmodule
`default_nettype wire

// [tb/rtcd_cmd_decoder_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module rtcd_cmd_decoder_bench;
   import rtcd_pkg::*;
   logic       sys_clk, arst_n, scl, sda_m, sda_out, sda_oe_n, sda_wire, ext_ok;
   logic       alarm_event, seconds_ind, minutes_ind, res_stb, exp_di, exp_am;
   logic       presc, sec_clr, carry, date_ig, alarm_f, pwr_loss;
   logic [1:0] addr_pins;
   logic [7:0] seconds_bcd;
   logic [8:0] res_val;
   logic [8:0] exp_q[$];
   logic [7:0] regs_e[8];
   logic [7:0] bad_cmd[4] = '{8'h80, 8'h70, 8'h08, 8'hC5};
   logic [7:0] cmd_tab[6] = '{8'h20, 8'h30, 8'h30, 8'h50, 8'h40, 8'h60};
   logic [7:0] sec_tab[6] = '{8'h00, 8'h29, 8'h30, 8'h00, 8'h00, 8'h00};
   int         bad_count, samples_checked, seed, n_p, n_s, n_c, e_p, e_s, e_c;
   // pull-up on the data line
   assign sda_wire = sda_m & (sda_oe_n | sda_out);
   rtcd_cmd_decoder uut (
      .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pins(addr_pins),
      .external_supply_fail_input(ext_ok), .seconds_bcd(seconds_bcd),
      .alarm_event(alarm_event), .seconds_ind(seconds_ind), .minutes_ind(minutes_ind),
      .prescaler_clear(presc), .seconds_clear(sec_clr), .minute_carry(carry),
      .date_ignore_flag(date_ig), .alarm_match_flag(alarm_f), .power_loss_flag(pwr_loss));
   rtcd_i2c_master m (.sys_clk(sys_clk), .scl(scl), .sda_m(sda_m), .sda_wire(sda_wire),
      .res_stb(res_stb), .res_val(res_val));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ****************************************************************
   // result watcher
   // ****************************************************************
   always @(posedge sys_clk) begin
      n_p += int'(presc === 1'b1);
      n_s += int'(sec_clr === 1'b1);
      n_c += int'(carry === 1'b1);
      if (res_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare result", res_val, 9'h1FF);
         end else begin
            check("bus byte", res_val, exp_q.pop_front());
         end
      end
   end
   function automatic logic [7:0] adr(input logic rw);
      return {ADDR_FIXED_DEF, addr_pins, rw};
   endfunction
   function automatic logic [7:0] msk(input int f);
      return f == 0 ? MASK_HOURS : f == 1 ? MASK_MINUTES : f == 2 ? MASK_DAYS : MASK_MONTHS;
   endfunction
   function automatic logic [7:0] flags_e();
      return {3'b000, minutes_ind, seconds_ind, exp_di, exp_am, ~ext_ok};
   endfunction
   task automatic wr(input logic [7:0] d, input logic a);
      exp_q.push_back({8'h00, a});
      m.wbyte(d);
   endtask
   task automatic rd(input logic [7:0] d, input logic last);
      exp_q.push_back({1'b1, d});
      m.rbyte(last);
   endtask
   task automatic cmd(input logic [7:0] c, input logic a);
      m.start();
      wr(adr(1'b0), 1'b1);
      wr(c, a);
   endtask
   task automatic wrn(input int b, input int f, input int n);
      int         idx;
      logic [7:0] d;
      cmd({1'b0, FC_SET_POINTER, 1'b0, b[0], f[1:0]}, 1'b1);
      for (int k = 0; k < n; k++) begin
         d = 8'($random(seed));
         idx = b * 4 + (f + k) % 4;
         regs_e[idx] = d & msk((f + k) % 4);
         wr(d, 1'b1);
      end
      m.stop();
   endtask
   task automatic rdn(input int b, input int f, input int n);
      m.start();
      wr(adr(1'b1), 1'b1);
      for (int k = 0; k < n; k++) begin
         rd(regs_e[b * 4 + (f + k) % 4], k == n - 1);
      end
      m.stop();
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      wrap_up();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      seed = 64292;
      {arst_n, alarm_event, seconds_ind, minutes_ind, exp_di, exp_am} = '0;
      {bad_count, samples_checked, n_p, n_s, n_c, e_p, e_s, e_c} = '0;
      ext_ok = 1'b1;
      seconds_bcd = 8'h00;
      addr_pins = 2'($random(seed));
      foreach (regs_e[i]) regs_e[i] = REG_RESET;
      repeat (16) @(negedge sys_clk);
      arst_n = 1'b1;
      m.gap(8);
      // fill time bank, pointer wraps to hours
      wrn(0, 0, 4);
      rdn(0, 0, 4);
      // reset values and wrap kept in alarm bank
      wrn(1, 2, 0);
      rdn(1, 2, 3);
      wrn(1, 3, 3);
      wrn(1, 0, 0);
      rdn(1, 0, 4);
      ext_ok = 1'b0;
      minutes_ind = 1'b1;
      cmd({1'b0, FC_READ_FLAGS, 4'h0}, 1'b1);
      wr(8'h12, 1'b0);
      m.stop();
      foreach (bad_cmd[i]) begin
         cmd(bad_cmd[i], 1'b0);
         m.stop();
      end
      // flags code survives refused commands
      // a read must clock out at least one byte and end it with a no-ack
      m.start();
      wr(adr(1'b1), 1'b1);
      rd(flags_e(), 1'b0);
      rd(flags_e(), 1'b0);
      rd(flags_e(), 1'b1);
      m.stop();
      // swap the indication levels so each flags bit is told apart
      {ext_ok, seconds_ind, minutes_ind} = 3'b110;
      alarm_event = 1'b1;
      m.gap(1);
      alarm_event = 1'b0;
      exp_am = 1'b1;
      for (int i = 0; i < 6; i++) begin
         seconds_bcd = sec_tab[i];
         cmd(cmd_tab[i], 1'b1);
         m.stop();
         e_p += int'(i == 0);
         e_s += int'(i < 3);
         e_c += int'(i == 2);
         exp_di = (i == 3) ? 1'b1 : (i == 4) ? 1'b0 : exp_di;
         exp_am = (i == 5) ? 1'b0 : exp_am;
         check("prescaler clears", 9'(n_p), 9'(e_p));
         check("seconds clears", 9'(n_s), 9'(e_s));
         check("minute carries", 9'(n_c), 9'(e_c));
         check("flag pins", {7'h00, date_ig, alarm_f}, {7'h00, exp_di, exp_am});
      end
      cmd({1'b0, FC_SET_DATE_IG, 4'h0}, 1'b1);
      m.stop();
      exp_di = 1'b1;
      cmd({1'b0, FC_READ_FLAGS, 4'h0}, 1'b1);
      m.stop();
      m.start();
      wr(adr(1'b1), 1'b1);
      rd(flags_e(), 1'b1);
      m.stop();
      check("power loss pin", {8'h00, pwr_loss}, 9'h000);
      m.gap(4);
      wrap_up();
   end
endmodule
`default_nettype wire
